//--- slsr_chk_sva.sv
// Checker for the link status register port
`timescale 1ns/1ps
`include "slsr_regs.vh"
module slsr_chk (
    input wire mclk,
    input wire rst_n,
    input wire [`SLSR_ADDR_W-1:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [31:0] reg_rdata,
    input wire phy_offline,
    input wire phy_dev_present,
    input wire phy_ready,
    input wire [1:0] phy_speed,
    input wire phy_partial,
    input wire phy_slumber
);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    wire rd0 = reg_rd && reg_addr == 4'h0;
    wire act = phy_ready & phy_dev_present & ~phy_offline & ~phy_partial
        & ~phy_slumber & phy_speed == 2'h1;
    a_rdata_idle: assert property (!$past(reg_rd) |->
        reg_rdata == 32'h0)
        else $error("read data not zero outside a read");
    a_rsvd_zero: assert property (reg_rdata[31:12] == 20'h0)
        else $error("reserved bits set");
    a_unmapped_zero: assert property ($past(reg_rd) &&
        $past(reg_addr) != 4'h0 |-> reg_rdata == 32'h0)
        else $error("unmapped read not zero");
    a_lowpwr_det: assert property ($past(rd0) &&
        reg_rdata[10:9] != 2'h0 |-> reg_rdata[3:1] == 3'h0)
        else $error("low power shows a link");
    a_enc_legal: assert property ($past(rd0) |->
        reg_rdata[3:0] inside {4'h0, 4'h1, 4'h3, 4'h4} &&
        reg_rdata[7:4] < 4'h3 &&
        reg_rdata[11:8] inside {4'h0, 4'h1, 4'h2, 4'h6})
        else $error("illegal field code");
    a_live_offline: assert property (phy_offline[*4] ##0 rd0
        |=> reg_rdata == 32'h4)
        else $error("offline not reported");
    a_live_active: assert property (act[*4] ##0 rd0
        |=> reg_rdata == 32'h113)
        else $error("active link not reported");
    a_wr_silent: assert property (reg_wr && !reg_rd |=>
        reg_rdata == 32'h0)
        else $error("write produced read data");
    c_active: cover property (act ##0 rd0);
    c_slumber: cover property ($past(rd0) && reg_rdata[11:8] == 4'h6);
    c_write: cover property (reg_wr);
endmodule
bind slsr_top slsr_chk i_chk (.mclk(mclk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .phy_offline(phy_offline),
    .phy_dev_present(phy_dev_present), .phy_ready(phy_ready),
    .phy_speed(phy_speed), .phy_partial(phy_partial),
    .phy_slumber(phy_slumber));

//--- slsr_regs.vh
// Register offsets, field layout and encodings of the link status block
// Behaviour
// - Provide a 32-bit read-only status register
// - Reads return condition at the read moment
// - Refresh continuously, independent of software reads
// - Writes are ignored, nothing changes
// - Reserved bits always read as zero
// - Low-power states report no device or link; the code reports the device as present (detect code 1) with no link
`ifndef SLSR_REGS_VH
`define SLSR_REGS_VH
// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define SLSR_ADDR_W 4
`define SLSR_OFS_LINK_STATUS 4'h0
`define SLSR_OFS_SRC_CTRL 4'h4
`define SLSR_STATUS_RESET 32'h0000_0000
`define SLSR_SRC_CTRL_RESET 32'h0000_0000
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SLSR_DET_LSB 0
`define SLSR_DET_MSB 3
`define SLSR_SPD_LSB 4
`define SLSR_SPD_MSB 7
`define SLSR_IPM_LSB 8
`define SLSR_IPM_MSB 11
// ----------------------------------------------------------------
// Encodings
// ----------------------------------------------------------------
`define SLSR_DET_NONE 4'h0
`define SLSR_DET_PRESENT 4'h1
`define SLSR_DET_LINKED 4'h3
`define SLSR_DET_OFFLINE 4'h4
`define SLSR_SPD_NONE 4'h0
`define SLSR_SPD_GEN1 4'h1
`define SLSR_SPD_GEN2 4'h2
`define SLSR_IPM_NONE 4'h0
`define SLSR_IPM_ACTIVE 4'h1
`define SLSR_IPM_PARTIAL 4'h2
`define SLSR_IPM_SLUMBER 4'h6
`endif

//--- slsr_sync.v
// Two-flop synchroniser for a bundle of level inputs
`timescale 1ns/1ps
module slsr_sync #(
    parameter W = 1
) (
    input wire mclk,
    input wire rst_n,
    input wire [W-1:0] async_in,
    output reg [W-1:0] sync_out
);
    reg [W-1:0] stage_one;

    // First stage read only by second stage
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            stage_one <= {W{1'b0}};
            sync_out <= {W{1'b0}};
        end else begin
            stage_one <= async_in;
            sync_out <= stage_one;
        end
    end
endmodule

//--- slsr_top.v
// Live serial link status register with a plain register port
//
// Implementation choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`include "slsr_regs.vh"
module slsr_top (
    input wire mclk,
    input wire rst_n,
    input wire [`SLSR_ADDR_W-1:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata,
    input wire phy_offline,
    input wire phy_dev_present,
    input wire phy_ready,
    input wire [1:0] phy_speed,
    input wire phy_partial,
    input wire phy_slumber
);
    // ------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------
    wire [6:0] phy_sync;
    wire s_offline;
    wire s_present;
    wire s_ready;
    wire [1:0] s_speed;
    wire s_partial;
    wire s_slumber;

    // Live pins resampled every clock, never tied to reads
    slsr_sync #(
        .W(7)
    ) u_sync (
        .mclk(mclk),
        .rst_n(rst_n),
        .async_in({phy_offline, phy_dev_present, phy_ready, phy_speed,
                   phy_partial, phy_slumber}),
        .sync_out(phy_sync)
    );

    assign s_offline = phy_sync[6];
    assign s_present = phy_sync[5];
    assign s_ready = phy_sync[4];
    assign s_speed = phy_sync[3:2];
    assign s_partial = phy_sync[1];
    assign s_slumber = phy_sync[0];

    // ------------------------------------------------------------
    // Field encoding
    // ------------------------------------------------------------
    reg [3:0] next_device_detect_state;
    reg [3:0] next_negotiated_speed_gen;
    reg [3:0] next_power_mgmt_state;
    reg [31:0] interface_link_status;
    wire low_power;

    // Slumber wins if PHY flags both at once
    assign low_power = s_partial | s_slumber;

    // Link counts as up only when online, present and ready
    function link_up;
        input off;
        input pres;
        input rdy;
        begin
            link_up = !off && pres && rdy;
        end
    endfunction

    always @* begin
        next_power_mgmt_state = `SLSR_IPM_NONE;
        if (!link_up(s_offline, s_present, s_ready)) begin
            next_power_mgmt_state = `SLSR_IPM_NONE;
        end else if (s_slumber) begin
            next_power_mgmt_state = `SLSR_IPM_SLUMBER;
        end else if (s_partial) begin
            next_power_mgmt_state = `SLSR_IPM_PARTIAL;
        end else begin
            next_power_mgmt_state = `SLSR_IPM_ACTIVE;
        end
    end

    always @* begin
        next_device_detect_state = `SLSR_DET_NONE;
        if (s_offline) begin
            next_device_detect_state = `SLSR_DET_OFFLINE;
        end else if (!s_present) begin
            next_device_detect_state = `SLSR_DET_NONE;
        end else if (low_power || !s_ready) begin
            // No active link while quiescent
            next_device_detect_state = `SLSR_DET_PRESENT;
        end else begin
            next_device_detect_state = `SLSR_DET_LINKED;
        end
    end

    always @* begin
        next_negotiated_speed_gen = `SLSR_SPD_NONE;
        if (link_up(s_offline, s_present, s_ready)) begin
            case (s_speed)
                2'h1: begin
                    next_negotiated_speed_gen = `SLSR_SPD_GEN1;
                end
                2'h2: begin
                    next_negotiated_speed_gen = `SLSR_SPD_GEN2;
                end
                default: begin
                    // Unknown rate shows as not negotiated
                    next_negotiated_speed_gen = `SLSR_SPD_NONE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Status register, refreshed every cycle
    // ------------------------------------------------------------
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            interface_link_status <= `SLSR_STATUS_RESET;
        end else begin
            // Upper bits constant zero
            interface_link_status <= {20'h00000,
                                      next_power_mgmt_state,
                                      next_negotiated_speed_gen,
                                      next_device_detect_state};
        end
    end

    // ------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------
    // Write strobe and data decode nowhere, so no state can change

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            // Value of the read cycle itself, not an old latch
            if (reg_addr == `SLSR_OFS_LINK_STATUS) begin
                reg_rdata <= interface_link_status;
            end else begin
                reg_rdata <= 32'h0000_0000;
            end
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end
endmodule

//--- tb_top.sv
// Self-checking bench for the link status register
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fail_count++; \
    $display("MISMATCH %0t %h %h", $time, a, b); end end
module tb_top;
    // ----------------------------------------
    // Stimulus and checks
    // ----------------------------------------
    reg mclk = 0, rst_n = 0, wr = 0, rd = 0;
    reg [3:0] addr = 4'h0;
    reg [31:0] wd = 32'h0;
    reg [6:0] p = 7'h0;
    wire [31:0] q;
    int fail_count = 0, n_tests = 0;
    slsr_top i_dut (.mclk(mclk), .rst_n(rst_n), .reg_addr(addr),
        .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd), .reg_rdata(q),
        .phy_offline(p[6]), .phy_dev_present(p[5]), .phy_ready(p[4]),
        .phy_speed(p[3:2]), .phy_partial(p[1]), .phy_slumber(p[0]));
    initial forever #4 mclk = ~mclk;
    task complete_run;
        $display("tests %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // Read data stand one cycle only, so sample just after that edge
    task rdr(input [3:0] a, output [31:0] v);
        @(posedge mclk);
        rd <= 1'b1;
        addr <= a;
        @(posedge mclk);
        rd <= 1'b0;
        #1 v = q;
    endtask
    // Pins settle through 3 edges before a read may see them
    task st(input [6:0] v, input [31:0] e);
        reg [31:0] g;
        @(posedge mclk) p <= v;
        repeat (4) @(posedge mclk);
        rdr(4'h0, g);
        `CHK(g, e)
    endtask
    task t_codes;
        st(7'h40, 32'h4);
        st(7'h00, 32'h0);
        st(7'h20, 32'h1);
        st(7'h34, 32'h113);
        st(7'h38, 32'h123);
        st(7'h3a, 32'h221);
        st(7'h35, 32'h611);
        st(7'h3b, 32'h621);
        $display("codes done");
    endtask
    task t_write;
        reg [31:0] g;
        st(7'h38, 32'h123);
        @(posedge mclk);
        wr <= 1'b1;
        addr <= 4'h0;
        wd <= 32'hffff_ffff;
        @(posedge mclk) addr <= 4'h4;
        @(posedge mclk) wr <= 1'b0;
        rdr(4'h0, g);
        `CHK(g, 32'h123)
        rdr(4'h4, g);
        `CHK(g, 32'h0)
        rdr(4'h8, g);
        `CHK(g, 32'h0)
        $display("write done");
    endtask
    initial begin
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        t_codes;
        t_write;
        complete_run;
    end
    initial begin
        #20000;
        fail_count++;
        complete_run;
    end
endmodule
